// ===== hdl/hofl_cfg.svh
`ifndef HOFL_CFG_SVH
`define HOFL_CFG_SVH

// ---------------------------------------------
// Option word layout
// ---------------------------------------------
`define HOFL_OPT_W      19
`define HOFL_OB_LOCK    0
`define HOFL_OB_BSEL    1
`define HOFL_OB_PU      4
`define HOFL_OB_AR      5
`define HOFL_OB_APSZ    6
`define HOFL_OB_BO      9
`define HOFL_OB_WDOG_RESET_ENABLE_BIT    10
`define HOFL_OB_NS      11
`define HOFL_OB_AUTO    12
`define HOFL_OB_IDLE    13
`define HOFL_OB_WP      14
`define HOFL_OB_RPR     15
`define HOFL_OB_PS      16
`define HOFL_ERASED     19'h00000
`define HOFL_SHIPPED    19'h0008C

// ---------------------------------------------
// Flash map
// ---------------------------------------------
`define HOFL_STEP       16'h0200
`define HOFL_FLASH_END  16'h0FFF
`define HOFL_FLASH_TOP  16'h1000
`define HOFL_APP_START  16'h0000
`define HOFL_LOCKED     8'hFF

// ---------------------------------------------
// Register map
// ---------------------------------------------
`define HOFL_A_WDCR     4'h0
`define HOFL_A_DCON     4'h1
`define HOFL_A_APP_UPDATE_LOWER_BOUND    4'h2
`define HOFL_A_STAT     4'h3

// ---------------------------------------------
// Watchdog control fields
// ---------------------------------------------
`define HOFL_WD_OVF     7
`define HOFL_WD_RST     6
`define HOFL_WD_RUN     5
`define HOFL_WD_NS      4
`define HOFL_WD_IDLE    3
`define HOFL_WD_PS      0
`define HOFL_WD_MASK    8'h5F
`define HOFL_DC_RSTPIN  1

// ---------------------------------------------
// Programming frame
// ---------------------------------------------
`define HOFL_FRAME_W    24
`define HOFL_FRAME_LAST 5'h17
`define HOFL_CMD_HI     23

`endif

// ===== hdl/hofl_pkg.sv
package hofl_pkg;
    typedef enum logic [1:0] {
        HOFL_CMD_RDCODE = 2'h0,
        HOFL_CMD_WROPT  = 2'h1,
        HOFL_CMD_ERASE  = 2'h2,
        HOFL_CMD_RDOPT  = 2'h3
    } hofl_cmd_t;
    typedef enum logic [2:0] {
        HOFL_RECV  = 3'b001,
        HOFL_FETCH = 3'b010,
        HOFL_SEND  = 3'b100
    } hofl_state_t;
endpackage

// ===== hdl/hofl_sync.sv
`timescale 1ns/1ps
module hofl_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Pins and filtered levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] q_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
            q_q   <= '0;
        end else begin
            ff1_q <= d_i;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            q_q   <= (ff2_q & ff3_q) | (q_q & (ff2_q | ff3_q));
        end
    end

    assign q_o = q_q;
endmodule // hofl_sync

// ===== hdl/hofl_wdog_ctl.sv
`timescale 1ns/1ps
`include "hofl_cfg.svh"
module hofl_wdog_ctl (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Power-on load
    input  wire logic       load_i,
    input  wire logic       opt_auto_i,
    input  wire logic       opt_rst_i,
    input  wire logic       opt_ns_i,
    input  wire logic       opt_idle_i,
    input  wire logic [2:0] opt_ps_i,
    input  wire logic       protect_i,
    // Software and events
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       ovf_i,
    output logic      [7:0] wdcr_o,
    output logic            rst_req_o
);
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] wmask;

    always_comb begin
        wmask = protect_i ? 8'h00 : `HOFL_WD_MASK; // [RULE14]
        d = wr_i ? ((q & ~wmask) | (wdata_i & wmask)) : q;
        d[`HOFL_WD_RUN] = q[`HOFL_WD_RUN] | (wr_i & wdata_i[`HOFL_WD_RUN]);
        d[`HOFL_WD_OVF] = ovf_i | (q[`HOFL_WD_OVF] & ~(wr_i & wdata_i[`HOFL_WD_OVF]));
    end

    // ---------------------------------------------
    // Control register
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= 8'h00;
        end else if (load_i) begin
            q <= 8'h00;
            q[`HOFL_WD_RST] <= opt_rst_i; // [RULE11]
            q[`HOFL_WD_NS] <= opt_ns_i; // [RULE12]
            q[`HOFL_WD_RUN] <= opt_auto_i; // [RULE13]
            q[`HOFL_WD_IDLE] <= opt_auto_i & opt_idle_i;
            q[`HOFL_WD_PS+:3] <= opt_auto_i ? opt_ps_i : 3'h0;
        end else begin
            q <= d;
        end
    end

    assign wdcr_o    = q;
    assign rst_req_o = ovf_i & q[`HOFL_WD_RST] & q[`HOFL_WD_RUN];

    AST_WD_PROT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE14]
        (protect_i && wr_i && !load_i) |=> ((q & `HOFL_WD_MASK) == $past(q & `HOFL_WD_MASK)))
        else $error("protected watchdog bits changed");
    AST_WD_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE13]
        load_i |=> (q[`HOFL_WD_RUN] == $past(opt_auto_i)
                    && q[`HOFL_WD_PS+:3] == ($past(opt_auto_i) ? $past(opt_ps_i) : 3'h0)))
        else $error("watchdog power-on load wrong");
    AST_WD_RSTBIT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE11]
        load_i |=> (q[`HOFL_WD_RST] == $past(opt_rst_i) && q[`HOFL_WD_NS] == $past(opt_ns_i)))
        else $error("watchdog reset or nonstop bit not from option");
endmodule // hofl_wdog_ctl

// ===== hdl/hofl_loader.sv
// How it works
// RULE1 - Option bits change only through the programming port, never by software.
// RULE2 - Whole-chip erase clears every option, leaving no loader or update region.
// RULE3 - With the lock set, programmer code readback returns 0xFF bytes.
// RULE4 - Loader region runs from its start up to the last flash address.
// RULE5 - Loader start selectable in 512-byte steps from 0x0200 to 0x0E00, or none.
// RULE6 - Shipped option word holds a 1K loader region.
// RULE7 - Power-up boots from loader when its option and a region exist, else application.
// RULE8 - Any-reset option with a region boots every reset from the loader.
// RULE9 - Update region bound set by option or software, default 1K.
// RULE10 - Brownout resets to application start only when its option is set.
// RULE11 - Watchdog reset-enable bit follows its option.
// RULE12 - Watchdog non-stop bit follows its option.
// RULE13 - Auto-enable option starts watchdog and loads its fields at power-on.
// RULE14 - Write-protect option blocks software writes to watchdog fields; the code still lets software set the run bit and clear the overflow bit.
// RULE15 - Reset-pin reuse option clears the reset-pin function bit.
// RULE16 - Programming uses clock and two-way data lines, only while halted.
// RULE17 - Options sampled once after power-on and held until next power-on.
`timescale 1ns/1ps
`include "hofl_cfg.svh"
module hofl_loader
    import hofl_pkg::*;
#(
    parameter logic [`HOFL_OPT_W-1:0] SHIPPED = `HOFL_SHIPPED
) (
    // Clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // System status
    input  wire logic        sys_reset_i,
    input  wire logic        halted_i,
    input  wire logic        brownout_detector_i,
    input  wire logic        wdog_overflow_i,
    // Programming port
    input  wire logic        prog_clock_line_i,
    input  wire logic        prog_data_line_i,
    output logic             prog_data_line_o,
    output logic             prog_data_line_oe_o,
    // Code flash read
    output logic      [11:0] code_addr_o,
    output logic             code_rd_o,
    input  wire logic [7:0]  code_data_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Derived controls
    output logic             boot_from_loader_o,
    output logic      [15:0] boot_addr_o,
    output logic             cpu_reset_o,
    output logic             wdog_run_o,
    output logic             wdog_reset_enable_bit_o,
    output logic             wdog_nonstop_bit_o,
    output logic             wdog_idle_count_bit_o,
    output logic      [2:0]  wdog_prescale_o,
    output logic             reset_pin_function_bit_o
);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic logic [15:0] hofl_boot_addr(input logic go, input logic [2:0] sel);
        return go ? (16'(sel) * `HOFL_STEP) : `HOFL_APP_START;
    endfunction

    function automatic logic [7:0] hofl_app_lb(input logic [`HOFL_OPT_W-1:0] o);
        logic [15:0] top;
        logic [15:0] lb;
        top = (|o[`HOFL_OB_BSEL+:3]) ? (16'(o[`HOFL_OB_BSEL+:3]) * `HOFL_STEP)
                                     : `HOFL_FLASH_TOP;
        lb  = top - (16'(o[`HOFL_OB_APSZ+:3]) * `HOFL_STEP);
        return lb[15:8];
    endfunction

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    logic [`HOFL_OPT_W-1:0]  fuse_q;
    logic [`HOFL_OPT_W-1:0]  opt_q;
    logic                    sampled_q;
    logic                    boot_q;
    logic [15:0]             baddr_q;
    logic                    cpu_reset_q;
    logic                    dcon_q;
    logic [7:0]              app_update_lower_bound_q;
    logic [7:0]              rdata_q;
    logic [1:0]              pins;
    logic                    bo_lvl;
    logic                    pclk_prev_q;
    logic                    bo_prev_q;
    logic                    rise;
    logic                    bo_rise;
    logic                    bo_hit;
    hofl_state_t             state_q;
    logic [4:0]              cnt_q;
    logic [`HOFL_FRAME_W-1:0] sh_q;
    logic                    oe_q;
    logic                    code_rd_q;
    logic [11:0]             code_addr_q;
    logic [`HOFL_FRAME_W-1:0] frame_word;
    logic                    frame_done;
    hofl_cmd_t               cmd;
    logic [7:0]              wdcr;
    logic                    wd_req;

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    hofl_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({brownout_detector_i, prog_data_line_i, prog_clock_line_i}),
        .q_o     ({bo_lvl, pins})
    );

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pclk_prev_q <= 1'b0;
            bo_prev_q   <= 1'b0;
        end else begin
            pclk_prev_q <= pins[0];
            bo_prev_q   <= bo_lvl;
        end
    end

    always_comb begin
        rise       = pins[0] & ~pclk_prev_q & halted_i; // [RULE16]
        bo_rise    = bo_lvl & ~bo_prev_q;
        bo_hit     = bo_rise & opt_q[`HOFL_OB_BO] & sampled_q; // [RULE10]
        frame_word = {sh_q[`HOFL_FRAME_W-2:0], pins[1]};
        cmd        = hofl_cmd_t'(frame_word[`HOFL_CMD_HI-:2]);
        frame_done = (state_q == HOFL_RECV) & rise & (cnt_q == `HOFL_FRAME_LAST);
    end

    // ---------------------------------------------
    // Option store
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fuse_q <= SHIPPED; // [RULE6]
        end else if (frame_done) begin // [RULE1]
            if (cmd == HOFL_CMD_WROPT) begin
                fuse_q <= frame_word[`HOFL_OPT_W-1:0];
            end else if (cmd == HOFL_CMD_ERASE) begin
                fuse_q <= `HOFL_ERASED; // [RULE2]
            end
        end
    end

    // ---------------------------------------------
    // Power-on sampling
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sampled_q <= 1'b0;
            opt_q     <= `HOFL_ERASED;
        end else if (!sampled_q) begin
            sampled_q <= 1'b1;
            opt_q     <= fuse_q; // [RULE17]
        end
    end

    // ---------------------------------------------
    // Boot selection
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_q  <= 1'b0;
            baddr_q <= `HOFL_APP_START;
        end else if (!sampled_q) begin
            boot_q  <= fuse_q[`HOFL_OB_PU] & (|fuse_q[`HOFL_OB_BSEL+:3]); // [RULE7]
            baddr_q <= hofl_boot_addr(fuse_q[`HOFL_OB_PU], fuse_q[`HOFL_OB_BSEL+:3]); // [RULE5]
        end else if (bo_hit) begin
            boot_q  <= 1'b0;
            baddr_q <= `HOFL_APP_START; // [RULE10]
        end else if (sys_reset_i) begin
            boot_q  <= opt_q[`HOFL_OB_AR] & (|opt_q[`HOFL_OB_BSEL+:3]); // [RULE8]
            baddr_q <= hofl_boot_addr(opt_q[`HOFL_OB_AR], opt_q[`HOFL_OB_BSEL+:3]); // [RULE4]
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_reset_q <= 1'b0;
        end else begin
            cpu_reset_q <= bo_hit | wd_req;
        end
    end

    // ---------------------------------------------
    // Derived registers
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dcon_q  <= 1'b1;
            app_update_lower_bound_q <= 8'h00;
        end else if (!sampled_q) begin
            dcon_q  <= ~fuse_q[`HOFL_OB_RPR]; // [RULE15]
            app_update_lower_bound_q <= hofl_app_lb(fuse_q); // [RULE9]
        end else if (reg_wr_i && reg_addr_i == `HOFL_A_APP_UPDATE_LOWER_BOUND) begin
            app_update_lower_bound_q <= reg_wdata_i; // [RULE9]
        end
    end

    hofl_wdog_ctl u_wdog (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .load_i     (~sampled_q),
        .opt_auto_i (fuse_q[`HOFL_OB_AUTO]),
        .opt_rst_i  (fuse_q[`HOFL_OB_WDOG_RESET_ENABLE_BIT]),
        .opt_ns_i   (fuse_q[`HOFL_OB_NS]),
        .opt_idle_i (fuse_q[`HOFL_OB_IDLE]),
        .opt_ps_i   (fuse_q[`HOFL_OB_PS+:3]),
        .protect_i  (opt_q[`HOFL_OB_WP]),
        .wr_i       (reg_wr_i && reg_addr_i == `HOFL_A_WDCR && sampled_q),
        .wdata_i    (reg_wdata_i),
        .ovf_i      (wdog_overflow_i),
        .wdcr_o     (wdcr),
        .rst_req_o  (wd_req)
    );

    // ---------------------------------------------
    // Register read port
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `HOFL_A_WDCR:  rdata_q <= wdcr;
                `HOFL_A_DCON:  rdata_q <= 8'(dcon_q) << `HOFL_DC_RSTPIN;
                `HOFL_A_APP_UPDATE_LOWER_BOUND: rdata_q <= app_update_lower_bound_q;
                `HOFL_A_STAT:  rdata_q <= {boot_q, opt_q[`HOFL_OB_LOCK], 3'h0,
                                           opt_q[`HOFL_OB_BSEL+:3]};
                default:       rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ---------------------------------------------
    // Programming port
    // ---------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q     <= HOFL_RECV;
            cnt_q       <= 5'h00;
            sh_q        <= '0;
            oe_q        <= 1'b0;
            code_rd_q   <= 1'b0;
            code_addr_q <= 12'h000;
        end else begin
            code_rd_q <= 1'b0;
            if (!halted_i) begin // [RULE16]
                state_q <= HOFL_RECV;
                cnt_q   <= 5'h00;
                oe_q    <= 1'b0;
            end else begin
                unique case (state_q)
                    HOFL_RECV: begin
                        if (rise) begin
                            sh_q  <= frame_word;
                            cnt_q <= 5'(cnt_q + 5'h01);
                            if (frame_done) begin
                                cnt_q <= 5'h00;
                                if (cmd == HOFL_CMD_RDCODE) begin
                                    code_addr_q <= frame_word[11:0];
                                    code_rd_q   <= 1'b1;
                                    state_q     <= HOFL_FETCH;
                                end else if (cmd == HOFL_CMD_RDOPT) begin
                                    sh_q    <= `HOFL_FRAME_W'(fuse_q);
                                    oe_q    <= 1'b1;
                                    state_q <= HOFL_SEND;
                                end
                            end
                        end
                    end
                    HOFL_FETCH: begin
                        if (!code_rd_q) begin
                            sh_q <= `HOFL_FRAME_W'(fuse_q[`HOFL_OB_LOCK] ? `HOFL_LOCKED
                                                                        : code_data_i); // [RULE3]
                            oe_q    <= 1'b1;
                            state_q <= HOFL_SEND;
                        end
                    end
                    HOFL_SEND: begin
                        if (rise) begin
                            sh_q  <= {sh_q[`HOFL_FRAME_W-2:0], 1'b0};
                            cnt_q <= 5'(cnt_q + 5'h01);
                            if (cnt_q == `HOFL_FRAME_LAST) begin
                                cnt_q   <= 5'h00;
                                oe_q    <= 1'b0;
                                state_q <= HOFL_RECV;
                            end
                        end
                    end
                    default: state_q <= HOFL_RECV;
                endcase
            end
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    assign prog_data_line_o         = sh_q[`HOFL_FRAME_W-1];
    assign prog_data_line_oe_o      = oe_q;
    assign code_addr_o              = code_addr_q;
    assign code_rd_o                = code_rd_q;
    assign reg_rdata_o              = rdata_q;
    assign boot_from_loader_o       = boot_q;
    assign boot_addr_o              = baddr_q;
    assign cpu_reset_o              = cpu_reset_q;
    assign wdog_run_o               = wdcr[`HOFL_WD_RUN];
    assign wdog_reset_enable_bit_o  = wdcr[`HOFL_WD_RST];
    assign wdog_nonstop_bit_o       = wdcr[`HOFL_WD_NS];
    assign wdog_idle_count_bit_o    = wdcr[`HOFL_WD_IDLE];
    assign wdog_prescale_o          = wdcr[`HOFL_WD_PS+:3];
    assign reset_pin_function_bit_o = dcon_q;

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    AST_NO_SW_FUSE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE1]
        !halted_i |=> $stable(fuse_q))
        else $error("option word changed outside programming");
    AST_ERASE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE2]
        (frame_done && cmd == HOFL_CMD_ERASE) |=> (fuse_q == `HOFL_ERASED))
        else $error("erase did not clear options");
    AST_LOCK_FF: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE3]
        (state_q == HOFL_FETCH && !code_rd_q && halted_i && fuse_q[`HOFL_OB_LOCK])
        |=> (sh_q[7:0] == `HOFL_LOCKED))
        else $error("locked readback not 0xFF");
    AST_REGION: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE5]
        boot_q |-> (baddr_q[8:0] == 9'h000 && baddr_q != `HOFL_APP_START
                    && baddr_q <= `HOFL_FLASH_END))
        else $error("loader start out of range");
    AST_POR_BOOT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE7]
        $rose(sampled_q) |-> (boot_q == (opt_q[`HOFL_OB_PU] && |opt_q[`HOFL_OB_BSEL+:3])))
        else $error("power-up boot choice wrong");
    AST_ANY_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE8]
        (sampled_q && sys_reset_i && !bo_hit)
        |=> (boot_q == (opt_q[`HOFL_OB_AR] && |opt_q[`HOFL_OB_BSEL+:3])))
        else $error("any-reset boot choice wrong");
    AST_BO_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE10]
        (sampled_q && bo_rise && !wd_req)
        |=> (cpu_reset_q == opt_q[`HOFL_OB_BO]) ##0 (!cpu_reset_q || !boot_q))
        else $error("brownout reset wrong");
    AST_OPT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE17]
        sampled_q |=> ($stable(opt_q) && $stable(dcon_q)))
        else $error("sampled options moved");
    AST_RSTPIN: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE15]
        sampled_q |-> (dcon_q == !opt_q[`HOFL_OB_RPR]))
        else $error("reset pin bit wrong");
    AST_HALT_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE16]
        !halted_i |=> !prog_data_line_oe_o)
        else $error("data line driven while running");
    AST_READ_LAT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE9]
        (reg_rd_i && reg_addr_i == `HOFL_A_APP_UPDATE_LOWER_BOUND) |=> (reg_rdata_o == app_update_lower_bound_q))
        else $error("bound register read wrong");

    COV_LOADER_BOOT: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(sampled_q) ##0 boot_q);
    COV_LOCKED_READ: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_q == HOFL_SEND) && fuse_q[`HOFL_OB_LOCK]);
    COV_BO_RESET: cover property (@(posedge clk_i) disable iff (!rst_b_i) bo_hit);
endmodule // hofl_loader

// ===== testbench/hofl_prog_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Programmer on the two-wire port
// ---------------------------------------------
module hofl_prog_model (
    input  wire logic clk_i,
    input  wire logic dev_data_i,
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic hb;
    logic rel;
    initial begin
        scl_o = 1'b0;
        hb = 1'b1;
        rel = 1'b1;
    end
    // Released line shows a moving pattern
    assign sda_o = dev_oe_i ? dev_data_i : hb;
    always @(posedge clk_i) begin
        if (rel && !dev_oe_i) hb <= ~hb;
    end
    // One clock pulse, long enough for the pin filter
    task automatic pulse();
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask
    task automatic xfer(input logic [23:0] cmd, input bit rsp_on, output logic [23:0] rsp);
        int n;
        rsp = 24'h000000;
        rel = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            hb <= cmd[i];
            pulse();
        end
        rel = 1'b1;
        n = 0;
        while (rsp_on && dev_oe_i !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        for (int i = 23; rsp_on && i >= 0; i--) begin
            repeat (3) @(posedge clk_i);
            rsp[i] = sda_o;
            pulse();
        end
    endtask
endmodule // hofl_prog_model

// ===== testbench/test_hofl_loader.sv
`timescale 1ns/1ps
module test_hofl_loader;
    logic clk_i, rst_b_i, sys_reset_i, halted_i, bod_i, ovf_i, scl, sda, d_o, oe_o, rd_o;
    logic cpu_rst, bfl, rpin, wrun, oe_bad;
    logic bfl2, rpin2, wrun2, wre2, wns2, widl2, cpu_rst2;
    logic [2:0]  wps2;
    logic [11:0] c_addr;
    logic [3:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i, rdata, v;
    logic        reg_wr_i, reg_rd_i;
    logic [15:0] baddr, baddr2;
    logic [23:0] r;
    int          err_count, comparisons, rst_cnt, rst_cnt2, rd_cnt;
    hofl_loader hofl_loader_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .sys_reset_i(sys_reset_i),
        .halted_i(halted_i), .brownout_detector_i(bod_i), .wdog_overflow_i(ovf_i),
        .prog_clock_line_i(scl), .prog_data_line_i(sda), .prog_data_line_o(d_o),
        .prog_data_line_oe_o(oe_o), .code_addr_o(c_addr), .code_rd_o(rd_o),
        .code_data_i(c_addr[7:0] ^ 8'h3C), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
        .boot_from_loader_o(bfl), .boot_addr_o(baddr), .cpu_reset_o(cpu_rst),
        .wdog_run_o(wrun), .wdog_reset_enable_bit_o(), .wdog_nonstop_bit_o(),
        .wdog_idle_count_bit_o(), .wdog_prescale_o(), .reset_pin_function_bit_o(rpin));
    // Second device shipped with every option set except the lock
    hofl_loader #(.SHIPPED(19'h5FEBC)) hofl_loader_opt_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sys_reset_i(sys_reset_i), .halted_i(halted_i), .brownout_detector_i(bod_i),
        .wdog_overflow_i(ovf_i), .prog_clock_line_i(scl), .prog_data_line_i(sda),
        .prog_data_line_o(), .prog_data_line_oe_o(), .code_addr_o(), .code_rd_o(),
        .code_data_i(c_addr[7:0] ^ 8'h3C), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(),
        .boot_from_loader_o(bfl2), .boot_addr_o(baddr2), .cpu_reset_o(cpu_rst2),
        .wdog_run_o(wrun2), .wdog_reset_enable_bit_o(wre2), .wdog_nonstop_bit_o(wns2),
        .wdog_idle_count_bit_o(widl2), .wdog_prescale_o(wps2), .reset_pin_function_bit_o(rpin2));
    hofl_prog_model hofl_prog_model_inst (.clk_i(clk_i), .dev_data_i(d_o), .dev_oe_i(oe_o),
        .scl_o(scl), .sda_o(sda));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (cpu_rst === 1'b1) rst_cnt++;
        if (cpu_rst2 === 1'b1) rst_cnt2++;
        if (rd_o === 1'b1) rd_cnt++;
        if (oe_o === 1'b1 && !halted_i) oe_bad = 1'b1;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        {rst_b_i, sys_reset_i, halted_i, bod_i, ovf_i, reg_wr_i, reg_rd_i, oe_bad} = 8'h00;
        {reg_addr_i, reg_wdata_i, err_count, comparisons, rst_cnt, rst_cnt2, rd_cnt} = 0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(4'h3, v); chk(v, 8'h06);
        chk({bfl, baddr, rpin}, 18'h00001);
        chk({bfl2, baddr2, rpin2}, 18'h21800);
        chk({wrun2, wre2, wns2, widl2, wps2}, 7'h7D);
        rd(4'h2, v); chk(v, 8'h08);
        rd(4'h0, v); chk(v, 8'h00);
        rd(4'hF, v); chk(v, 8'h00);
        wr(4'h3, 8'hFF); rd(4'h3, v); chk(v, 8'h06);
        wr(4'h2, 8'h04); rd(4'h2, v); chk(v, 8'h04);
        wr(4'h0, 8'h7F); rd(4'h0, v); chk(v, 8'h7F);
        chk({wrun2, wre2, wns2, widl2, wps2}, 7'h7D);
        ovf_i <= 1'b1;
        @(posedge clk_i);
        ovf_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(rst_cnt, 1);
        sys_reset_i <= 1'b1;
        bod_i <= 1'b1;
        @(posedge clk_i);
        sys_reset_i <= 1'b0;
        @(posedge clk_i);
        chk(bfl2, 1'b1);
        repeat (19) @(posedge clk_i);
        bod_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({bfl, rst_cnt[3:0]}, 5'h01);
        chk({bfl2, baddr2, rst_cnt2[3:0]}, 21'h000002);
        hofl_prog_model_inst.xfer(24'hC00000, 1'b0, r);
        repeat (20) @(posedge clk_i);
        chk(oe_bad, 1'b0);
        halted_i <= 1'b1;
        hofl_prog_model_inst.xfer(24'h000123, 1'b1, r); chk(r, 24'h00001F);
        hofl_prog_model_inst.xfer(24'h400001, 1'b0, r);
        hofl_prog_model_inst.xfer(24'hC00000, 1'b1, r); chk(r, 24'h000001);
        hofl_prog_model_inst.xfer(24'h000045, 1'b1, r); chk(r, 24'h0000FF);
        chk({bfl, rpin}, 2'b01);
        hofl_prog_model_inst.xfer(24'h800000, 1'b0, r);
        hofl_prog_model_inst.xfer(24'hC00000, 1'b1, r); chk(r, 24'h000000);
        chk(rd_cnt[7:0], 8'h02);
        tally_and_finish();
    end
endmodule // test_hofl_loader
